// file: include/trsd_pkg.sv
// trsd_pkg: constants and carrier types of the register service message handler
// assumes byte streams on both sides, one byte per valid/ready beat
package trsd_pkg;

  // ----------------------------------------------------------------------
  // message layout
  // ----------------------------------------------------------------------
  localparam logic [7:0]  TRSD_FN_DIAG      = 8'h08;
  localparam logic [7:0]  TRSD_FN_WRMULTI   = 8'h10;
  localparam logic [7:0]  TRSD_FN_ERRBIT    = 8'h80;
  localparam logic [15:0] TRSD_SUBFN_ECHO   = 16'h0000;
  localparam logic [15:0] TRSD_PROTO_ID     = 16'h0000;
  localparam logic [7:0]  TRSD_BCNT_MIN     = 8'h02;
  localparam logic [7:0]  TRSD_BCNT_MAX     = 8'hFA;
  localparam logic [15:0] TRSD_PCNT_MAX     = 16'h007D;
  localparam logic [7:0]  TRSD_EXC_FUNC     = 8'h01;
  localparam logic [7:0]  TRSD_EXC_ADDR     = 8'h02;
  localparam logic [7:0]  TRSD_EXC_DATA     = 8'h03;
  localparam logic [15:0] TRSD_ERR_LEN      = 16'h0003;
  localparam logic [15:0] TRSD_WR_RSP_LEN   = 16'h0006;
  localparam logic [15:0] TRSD_REG_COUNT    = 16'h0400;
  localparam logic [7:0]  TRSD_HDR_BYTES    = 8'h07;
  localparam logic [7:0]  TRSD_RSP_MAX      = 8'h10;

  // ----------------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------------
  localparam int TRSD_FIFO_WIDTH = 8;
  localparam int TRSD_FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } trsd_byte_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [15:0] data;
  } trsd_wr_t;

endpackage

// file: design/trsd_fifo.sv
// trsd_fifo: synchronous fifo with valid/ready on both sides
// assumes a single clock; full and empty come straight from the count
`timescale 1ns/1ps
module trsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= in_data;
    end
    if (reset)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop)
      begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: design/trsd_top.sv
// trsd_top: query parser and response builder for diagnostics echo and
// multiple holding register write
// assumes query bytes arrive framed by last; a link error on the last byte drops the query unanswered
`timescale 1ns/1ps
module trsd_top
  import trsd_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               q_valid,
  output logic                    q_ready,
  input  wire logic [7:0]         q_data,
  input  wire logic               q_last,
  input  wire logic               q_link_err,
  output trsd_pkg::trsd_byte_t    r_byte,
  input  wire logic               r_ready,
  output trsd_pkg::trsd_wr_t      reg_wr
);
  import trsd_pkg::*;

  // ----------------------------------------------------------------------
  // query buffer: decouples the link from the parser
  // ----------------------------------------------------------------------
  logic       f_valid;
  logic       f_ready;
  logic [9:0] f_data;
  logic       f_in_ready;

  assign q_ready = f_in_ready;

  // the link error flag rides with its byte; the parser acts on it only when that byte is the last
  trsd_fifo #(
    .WIDTH (TRSD_FIFO_WIDTH + 2),
    .DEPTH (TRSD_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (q_valid),
    .in_ready  (f_in_ready),
    .in_data   ({q_link_err, q_last, q_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RECV  = 3'b000,
    ST_DRAIN = 3'b001,
    ST_WRITE = 3'b010,
    ST_SEND  = 3'b011
  } trsd_st_t;

  typedef struct packed {
    trsd_st_t    st;
    logic [8:0]  idx;  // a full 125-word write runs to byte 262
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] pcnt;
    logic [7:0]  bcnt;
    logic [7:0]  exc;
    logic        drop;
    logic        hi_seen;
    logic [7:0]  hi_byte;
    logic [7:0]  wptr;
    logic [7:0]  rlen;
    logic [7:0]  rptr;
    trsd_byte_t  rb;
    trsd_wr_t    wr;
  } trsd_state_t;

  trsd_state_t s_ff;
  trsd_state_t nxt_s;

  // header and echo image; words buffered until all checks passed
  logic [7:0]  rsp_ff [TRSD_RSP_MAX];
  logic [15:0] wbuf_ff [128];
  logic [7:0]  b;
  logic        lst;
  logic        lerr;
  logic        take;

  function automatic logic [15:0] be16(input logic [7:0] h, input logic [7:0] l);
    be16 = {h, l};
  endfunction

  assign b      = f_data[7:0];
  assign lst    = f_data[8];
  assign lerr   = f_data[9];
  // only the parser pops; a byte taken while draining would be lost
  assign f_ready = (s_ff.st == ST_RECV);
  assign take   = f_valid && f_ready;
  assign r_byte = s_ff.rb;
  assign reg_wr = s_ff.wr;

  always_comb
  begin
    nxt_s       = s_ff;
    nxt_s.wr.en = 1'b0;
    case (s_ff.st)
      ST_RECV:
      begin
        if (take)
        begin
          nxt_s.idx = s_ff.idx + 9'h001;
          case (s_ff.idx)
            9'h002, 9'h003: if (b != 8'h00) nxt_s.drop = 1'b1;
            9'h007: nxt_s.func = b;
            9'h008: nxt_s.addr[15:8] = b;
            9'h009: nxt_s.addr[7:0] = b;
            9'h00A: nxt_s.pcnt[15:8] = b;
            9'h00B: nxt_s.pcnt[7:0] = b;
            9'h00C: nxt_s.bcnt = b;
            default: ;
          endcase
          if (s_ff.func == TRSD_FN_DIAG && s_ff.idx >= 9'h008)
          begin
            nxt_s.hi_seen = 1'b0;
          end
          if (s_ff.func == TRSD_FN_WRMULTI && s_ff.idx >= 9'h00D)
          begin
            nxt_s.hi_seen = !s_ff.hi_seen;
            nxt_s.hi_byte = b;
          end
          if (lst)
          begin
            nxt_s.st  = ST_RECV;
            nxt_s.idx = 9'h000;
            nxt_s.exc = 8'h00;
            nxt_s.hi_seen = 1'b0;
            if (s_ff.drop || lerr || (s_ff.idx == 9'h002 || s_ff.idx == 9'h003)
                && b != 8'h00)
            begin
              nxt_s.drop = 1'b0;
            end
            else if (s_ff.func == TRSD_FN_DIAG)
            begin
              if (s_ff.addr != TRSD_SUBFN_ECHO || s_ff.idx != 9'h00B)
              begin
                nxt_s.exc  = TRSD_EXC_DATA;
                nxt_s.rlen = 8'd9;
              end
              else
              begin
                nxt_s.rlen = 8'd12;
              end
              nxt_s.st = ST_SEND;
            end
            else if (s_ff.func == TRSD_FN_WRMULTI)
            begin
              nxt_s.st   = ST_SEND;
              nxt_s.rlen = 8'd12;
              if (s_ff.pcnt == 16'h0000 || s_ff.pcnt > TRSD_PCNT_MAX
                  || s_ff.bcnt < TRSD_BCNT_MIN || s_ff.bcnt > TRSD_BCNT_MAX
                  || {8'h00, s_ff.bcnt} != {s_ff.pcnt[14:0], 1'b0}
                  || {7'h00, s_ff.idx} != 16'd12 + {8'h00, s_ff.bcnt})
              begin
                nxt_s.exc  = TRSD_EXC_DATA;
                nxt_s.rlen = 8'd9;
              end
              else if ({1'b0, s_ff.addr} + {1'b0, s_ff.pcnt} > {1'b0, TRSD_REG_COUNT})
              begin
                nxt_s.exc  = TRSD_EXC_ADDR;
                nxt_s.rlen = 8'd9;
              end
              else
              begin
                nxt_s.st   = ST_WRITE;
                nxt_s.wptr = 8'h00;
              end
            end
            else
            begin
              nxt_s.exc  = TRSD_EXC_FUNC;
              nxt_s.rlen = 8'd9;
              nxt_s.st   = ST_SEND;
            end
            nxt_s.rptr = 8'h00;
          end
        end
      end
      ST_WRITE:
      begin
        nxt_s.wr.en   = 1'b1;
        nxt_s.wr.addr = s_ff.addr + {8'h00, s_ff.wptr};
        nxt_s.wr.data = wbuf_ff[s_ff.wptr[6:0]];
        nxt_s.wptr    = s_ff.wptr + 8'h01;
        if ({8'h00, s_ff.wptr} + 16'h0001 == s_ff.pcnt)
        begin
          nxt_s.st = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (!s_ff.rb.valid || r_ready)
        begin
          nxt_s.rb.valid = 1'b1;
          nxt_s.rb.last  = (s_ff.rptr + 8'h01 == s_ff.rlen);
          case (s_ff.rptr)
            8'd2, 8'd3: nxt_s.rb.data = TRSD_PROTO_ID[7:0];
            8'd4: nxt_s.rb.data = 8'h00;
            8'd5: nxt_s.rb.data = s_ff.rlen - 8'd6;
            8'd7: nxt_s.rb.data = (s_ff.exc != 8'h00) ? (TRSD_FN_ERRBIT | s_ff.func)
                                                      : s_ff.func;
            8'd8: nxt_s.rb.data = (s_ff.exc != 8'h00) ? s_ff.exc : rsp_ff[8];
            default: nxt_s.rb.data = rsp_ff[s_ff.rptr[3:0]];
          endcase
          nxt_s.rptr = s_ff.rptr + 8'h01;
          if (s_ff.rptr + 8'h01 == s_ff.rlen)
          begin
            nxt_s.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN:
      begin
        if (r_ready)
        begin
          nxt_s.rb.valid = 1'b0;
          nxt_s.rb.last  = 1'b0;
          nxt_s.st       = ST_RECV;
        end
      end
      default: nxt_s.st = ST_RECV;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (take && s_ff.st == ST_RECV && s_ff.idx < {1'b0, TRSD_RSP_MAX})
    begin
      rsp_ff[s_ff.idx[3:0]] <= b;
    end
    if (take && s_ff.st == ST_RECV && s_ff.func == TRSD_FN_WRMULTI
        && s_ff.idx >= 9'h00D && s_ff.hi_seen)
    begin
      wbuf_ff[7'((s_ff.idx - 9'h00E) >> 1)] <= be16(s_ff.hi_byte, b);
    end
    if (reset)
    begin
      s_ff    <= '0;
      s_ff.st <= ST_RECV;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end
endmodule

// file: tb/trsd_top_chk.sv
// trsd_top_chk: port assertions of the message handler
// assumes one clock domain, bound to every trsd_top
`timescale 1ns/1ps
module trsd_top_chk
  import trsd_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 q_valid,
  input wire logic                 q_ready,
  input wire trsd_pkg::trsd_byte_t r_byte,
  input wire logic                 r_ready,
  input wire trsd_pkg::trsd_wr_t   reg_wr
);
  logic [3:0] idx_ff;
  logic [7:0] len_ff;
  wire        acc = r_byte.valid && r_ready;
  // byte position inside the response frame, length byte kept for the tail
  always_ff @(posedge clk_sys)
  begin
    if (reset) idx_ff <= 4'h0;
    else if (acc) idx_ff <= r_byte.last ? 4'h0 : idx_ff + 4'h1;
    if (acc && idx_ff == 4'h5) len_ff <= r_byte.data;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rsp_hold: assert property (
    r_byte.valid && !r_ready |=> r_byte.valid && $stable(r_byte))
    else $error("response byte changed while stalled");
  a_proto_zero: assert property (
    acc && (idx_ff == 4'h2 || idx_ff == 4'h3) |-> r_byte.data == 8'h00)
    else $error("protocol id byte not zero");
  a_len_high: assert property (
    acc && idx_ff == 4'h4 |-> r_byte.data == 8'h00)
    else $error("length high byte not zero");
  a_len_low: assert property (
    acc && idx_ff == 4'h5 |-> r_byte.data inside {8'h03, 8'h06})
    else $error("length low byte wrong");
  a_last_place: assert property (
    acc && r_byte.last |-> idx_ff == len_ff[3:0] + 4'h5)
    else $error("frame end disagrees with length");
  a_err_flag: assert property (
    acc && idx_ff == 4'h7 && len_ff == 8'h03 |-> r_byte.data[7])
    else $error("error response without error bit");
  a_wr_quiet: assert property (reg_wr.en |-> !r_byte.valid)
    else $error("register write during response");
  a_wr_step: assert property (
    reg_wr.en && $past(reg_wr.en) |-> reg_wr.addr == $past(reg_wr.addr) + 16'h0001)
    else $error("write addresses not consecutive");
  a_wr_range: assert property (reg_wr.en |-> reg_wr.addr < TRSD_REG_COUNT)
    else $error("write outside register space");
  a_rsp_after_wr: assert property ($fell(reg_wr.en) |-> ##[1:64] r_byte.valid)
    else $error("no response after writes");
  c_echo: cover property (acc && idx_ff == 4'h7 && r_byte.data == TRSD_FN_DIAG);
  c_error: cover property (acc && len_ff == 8'h03 && r_byte.last);
  c_refuse: cover property (q_valid && !q_ready);
  c_write: cover property (reg_wr.en && $past(reg_wr.en));
endmodule

bind trsd_top trsd_top_chk u_chk (.clk_sys, .reset, .q_valid, .q_ready, .r_byte, .r_ready,
                                  .reg_wr);

// file: tb/trsd_master_model.sv
// trsd_master_model: network master sending queries, collecting responses
// assumes caller builds whole frames; responses kept as {last,data}
`timescale 1ns/1ps
module trsd_master_model
  import trsd_pkg::*;
(
  input  wire logic                 clk_sys,
  output logic                      q_valid,
  input  wire logic                 q_ready,
  output logic [7:0]                q_data,
  output logic                      q_last,
  output logic                      q_link_err,
  input  wire trsd_pkg::trsd_byte_t r_byte,
  output logic                      r_ready,
  input  wire logic                 slow
);
  logic [8:0] rsp_q[$];
  logic [3:0] pace;
  logic       stalled;
  initial
  begin
    {q_valid, q_data, q_last, q_link_err, r_ready, pace, stalled} = '0;
  end
  // slow sink takes one byte in four so queries back up into the fifo
  always @(negedge clk_sys)
  begin
    pace <= pace + 4'h1;
    r_ready <= !slow || pace[1:0] == 2'h0;
  end
  always @(posedge clk_sys)
  begin
    if (r_byte.valid && r_ready) rsp_q.push_back({r_byte.last, r_byte.data});
    if (q_valid && !q_ready) stalled = 1'b1;
  end
  // ----------------------------------------------------------------
  // one frame, bytes in order, error flag only with the last byte
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b[$], input logic err);
    for (int i = 0; i < b.size(); i++)
    begin
      @(negedge clk_sys);
      q_valid = 1'b1;
      q_data = b[i];
      q_last = i == b.size() - 1;
      q_link_err = err && q_last;
      @(posedge clk_sys);
      while (!q_ready) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    q_valid = 1'b0;
    q_data = ~q_data;
    {q_last, q_link_err} = 2'b00;
  endtask
endmodule

// file: tb/tb_trsd_top.sv
// tb_trsd_top: bench of the message handler against a queue model
// assumes the master model and the bound checker sit beside it
`timescale 1ns/1ps
module tb_trsd_top;
  import trsd_pkg::*;
  logic        clk_sys, reset, q_valid, q_ready, q_last, q_link_err, r_ready, slow;
  logic [7:0]  q_data;
  trsd_byte_t  r_byte;
  trsd_wr_t    reg_wr;
  logic [8:0]  exp_q[$];
  logic [31:0] wexp_q[$], wgot_q[$], seed;
  int          n_errors, num_checks, cyc;
  trsd_top uut (.clk_sys, .reset, .q_valid, .q_ready, .q_data, .q_last, .q_link_err,
                .r_byte, .r_ready, .reg_wr);
  trsd_master_model m (.clk_sys, .q_valid, .q_ready, .q_data, .q_last, .q_link_err,
                       .r_byte, .r_ready, .slow);
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (reg_wr.en === 1'b1) wgot_q.push_back({reg_wr.addr, reg_wr.data});
    if (cyc == 20000) begin n_errors++; close_out(); end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // model: frame the body, predict response and writes, then send
  // ----------------------------------------------------------------
  task automatic query(input logic [15:0] pid, input logic err, input logic [7:0] b[$]);
    logic [7:0]  f[$], r[$], code;
    logic [15:0] a, n, len;
    logic [31:0] t;
    t = rnd();
    len = 16'(b.size() + 1);
    f = {t[15:8], t[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], t[23:16]};
    f = {f, b};
    a = {b[1], b[2]};
    n = {b[3], b[4]};
    code = 8'h00;
    r = f;
    if (b[0] == TRSD_FN_DIAG)
    begin
      if (b.size() != 5 || a != TRSD_SUBFN_ECHO) code = TRSD_EXC_DATA;
    end
    else if (b[0] != TRSD_FN_WRMULTI) code = TRSD_EXC_FUNC;
    else if (n > TRSD_PCNT_MAX || {8'h00, b[5]} != n * 2 || b.size() != 6 + b[5])
      code = TRSD_EXC_DATA;
    else if ({1'b0, a} + n > TRSD_REG_COUNT) code = TRSD_EXC_ADDR;
    else
    begin
      r = {f[0:3], 8'h00, 8'h06, f[6:11]};
      for (int k = 0; k < n; k++)
        wexp_q.push_back({a + 16'(k), b[6 + 2 * k], b[7 + 2 * k]});
    end
    if (code != 8'h00) r = {f[0:3], 8'h00, 8'h03, f[6], TRSD_FN_ERRBIT | b[0], code};
    if (pid == TRSD_PROTO_ID && !err) foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    m.send(f, err);
  endtask
  task automatic wq(input logic [15:0] a, input logic [15:0] n, input logic [7:0] bc, input int nw);
    logic [7:0]  b[$];
    logic [31:0] t;
    b = {TRSD_FN_WRMULTI, a[15:8], a[7:0], n[15:8], n[7:0], bc};
    repeat (nw) begin t = rnd(); b.push_back(t[15:8]); b.push_back(t[7:0]); end
    query(TRSD_PROTO_ID, 1'b0, b);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    seed = 32'd29317;
    {reset, slow, n_errors, num_checks, cyc} = '1;
    {slow, n_errors, num_checks, cyc} = '0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    query(16'h0000, 1'b0, {8'h08, 8'h00, 8'h00, 8'hFF, 8'hFF});
    repeat (2) query(16'h0000, 1'b0, {8'h08, 8'h00, 8'h00, 8'(rnd()), 8'(rnd())});
    wq(16'h03EE, 16'h0002, 8'h04, 2);
    slow = 1'b1;
    wq(16'h0000, 16'h007D, 8'hFA, 125);
    wq(16'h03FF, 16'h0001, 8'h02, 1);
    wq(16'h03FF, 16'h0002, 8'h04, 2);
    wq(16'h0000, 16'h007E, 8'hFC, 126);
    wq(16'h0000, 16'h0002, 8'h06, 2);
    wq(16'h0000, 16'h0002, 8'h04, 3);
    query(16'h0000, 1'b0, {8'h08, 8'h00, 8'h01, 8'h12, 8'h34});
    query(16'h0000, 1'b0, {8'h03, 8'h00, 8'h00, 8'h00, 8'h01});
    query(16'h0001, 1'b0, {8'h08, 8'h00, 8'h00, 8'h55, 8'hAA});
    query(16'h0000, 1'b1, {8'h08, 8'h00, 8'h00, 8'h55, 8'hAA});
    slow = 1'b0;
    query(16'h0000, 1'b0, {8'h08, 8'h00, 8'h00, 8'hA5, 8'h5A});
    for (int k = 0; k < 8000 && m.rsp_q.size() < exp_q.size(); k++) @(posedge clk_sys);
    repeat (60) @(posedge clk_sys);
    check("response bytes", exp_q.size(), m.rsp_q.size());
    foreach (exp_q[i])
      if (i < m.rsp_q.size()) check("response byte", exp_q[i], m.rsp_q[i]);
    check("write count", wexp_q.size(), wgot_q.size());
    foreach (wexp_q[i]) if (i < wgot_q.size()) check("write", wexp_q[i], wgot_q[i]);
    check("query refused", 1, m.stalled);
    close_out();
  end
endmodule
